// [rtl/iod_addr_form.sv]
`timescale 1ns/10ps
`default_nettype none

`include "iod_defines.svh"

module iod_addr_form #(
  parameter int ADDR_W = 12
) (
  input  wire logic [ADDR_W-1:0] framePtr,
  input  wire logic [3:0]        bankSel,
  input  wire logic              extEnable,
  input  wire logic              accessBit,
  input  wire logic [7:0]        fileArg,
  output logic      [ADDR_W-1:0] dataAddr,
  output logic                   indexed
);

  logic [ADDR_W-1:0] idxSum;
  logic [ADDR_W-1:0] accessAddr;

  // Frame pointer plus zero-extended offset, wrapping in the address width
  assign idxSum = framePtr + ADDR_W'(fileArg);

  // Access bank: arguments up to IOD_IDX_LIMIT (0x5F) in bank 0, higher arguments in the top bank
  assign accessAddr = (fileArg > `IOD_IDX_LIMIT) ? {{(ADDR_W-8){1'b1}}, fileArg}
                                                 : ADDR_W'(fileArg);

  always_comb begin
    indexed  = extEnable && !accessBit && (fileArg <= `IOD_IDX_LIMIT);
    if (accessBit) begin
      dataAddr = ADDR_W'({bankSel, fileArg});
    end else if (indexed) begin
      dataAddr = idxSum;
    end else begin
      dataAddr = accessAddr;
    end
  end

endmodule : iod_addr_form

`default_nettype wire

// [rtl/iod_core.sv]
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

`include "iod_defines.svh"

module iod_core
  import iod_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [3:0]        regAddr,
  input  wire logic [15:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [15:0]       regRdData,
  input  wire logic              instrValid,
  input  wire logic [15:0]       instrWord,
  input  wire logic              fileOp,
  input  wire logic [7:0]        memRdData,
  output logic      [ADDR_W-1:0] memAddr,
  output logic                   memRead,
  output logic      [ADDR_W-1:0] memWrAddr,
  output logic                   memWrite,
  output logic      [7:0]        memWrData,
  output logic                   statusWrite,
  output logic                   carryOut,
  output logic                   extEnabled
);

  logic              extEnable;
  logic              next_extEnable;
  logic [ADDR_W-1:0] framePtr;
  logic [ADDR_W-1:0] next_framePtr;
  logic [3:0]        bankSel;
  logic [3:0]        next_bankSel;
  logic [7:0]        accum;
  logic [7:0]        next_accum;
  logic [ADDR_W-1:0] lastAddr;
  logic [ADDR_W-1:0] next_lastAddr;
  logic [15:0]       next_regRdData;

  iod_dec_s          decA;
  iod_dec_s          next_decA;
  iod_dec_s          decB;
  iod_dec_s          next_decB;

  logic [ADDR_W-1:0] next_memWrAddr;
  logic              next_memWrite;
  logic [7:0]        next_memWrData;
  logic              next_statusWrite;
  logic              next_carryOut;

  logic [ADDR_W-1:0] formAddr;
  logic              formIndexed;
  logic [8:0]        addSum;

  iod_addr_form #(
    .ADDR_W (ADDR_W)
  ) u_addr_form (
    .framePtr  (framePtr),
    .bankSel   (bankSel),
    .extEnable (extEnable),
    .accessBit (instrWord[`IOD_ACCESS_BIT]),
    .fileArg   (instrWord[7:0]),
    .dataAddr  (formAddr),
    .indexed   (formIndexed)
  );

  assign memAddr    = decA.addr;
  assign memRead    = decA.valid;
  assign extEnabled = extEnable;
  assign addSum     = {1'b0, accum} + {1'b0, memRdData};

  // Register port
  always_comb begin
    next_extEnable = extEnable;
    next_framePtr  = framePtr;
    next_bankSel   = bankSel;
    next_regRdData = 16'h0000;
    if (regWr) begin
      case (regAddr)
        `IOD_REG_CTRL:  next_extEnable = regWrData[`IOD_CTRL_EXT_BIT];
        `IOD_REG_FRAME: next_framePtr  = regWrData[ADDR_W-1:0];
        `IOD_REG_BANK:  next_bankSel   = regWrData[3:0];
        default:        next_extEnable = extEnable;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `IOD_REG_CTRL:     next_regRdData = {15'h0000, extEnable};
        `IOD_REG_FRAME:    next_regRdData = 16'(framePtr);
        `IOD_REG_BANK:     next_regRdData = {12'h000, bankSel};
        `IOD_REG_ACCUM:    next_regRdData = {8'h00, accum};
        `IOD_REG_LASTADDR: next_regRdData = 16'(lastAddr);
        default:           next_regRdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extEnable <= `IOD_CTRL_RST;
      framePtr  <= ADDR_W'(`IOD_FRAME_RST);
      bankSel   <= `IOD_BANK_RST;
      regRdData <= 16'h0000;
    end else begin
      extEnable <= next_extEnable;
      framePtr  <= next_framePtr;
      bankSel   <= next_bankSel;
      regRdData <= next_regRdData;
    end
  end

  // Decode stage: address formed for every file-argument instruction
  always_comb begin
    next_decA         = '0;
    next_lastAddr     = lastAddr;
    if (instrValid && fileOp) begin
      next_decA.valid   = 1'b1;
      next_decA.addr    = formAddr;
      next_decA.indexed = formIndexed;
      next_decA.destMem = instrWord[`IOD_DEST_BIT];
      next_decA.bitSel  = instrWord[11:9];
      next_lastAddr     = formAddr;
      if (instrWord[15:10] == `IOD_ADD_OPC) begin
        next_decA.op = OP_ADD;
      end else if (instrWord[15:12] == `IOD_BITSET_OPC) begin
        next_decA.op = OP_BITSET;
      end else if (instrWord[15:9] == `IOD_FILL_OPC) begin
        next_decA.op = OP_FILL;
      end else begin
        next_decA.op = OP_OTHER;
      end
    end
    next_decB = decA;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      decA     <= '0;
      decB     <= '0;
      lastAddr <= ADDR_W'(`IOD_FRAME_RST);
    end else begin
      decA     <= next_decA;
      decB     <= next_decB;
      lastAddr <= next_lastAddr;
    end
  end

  // Write-back stage: memory data has arrived for decB
  always_comb begin
    next_accum       = accum;
    next_memWrAddr   = decB.addr;
    next_memWrite    = 1'b0;
    next_memWrData   = 8'h00;
    next_statusWrite = 1'b0;
    next_carryOut    = carryOut;
    if (decB.valid) begin
      case (decB.op)
        OP_ADD: begin
          next_statusWrite = 1'b1;
          next_carryOut    = addSum[8];
          if (decB.destMem) begin
            next_memWrite  = 1'b1;
            next_memWrData = addSum[7:0];
          end else begin
            next_accum     = addSum[7:0];
          end
        end
        OP_BITSET: begin
          next_memWrite  = 1'b1;
          next_memWrData = memRdData | (8'h01 << decB.bitSel);
        end
        OP_FILL: begin
          next_memWrite  = 1'b1;
          next_memWrData = `IOD_FILL_VALUE;
        end
        default: next_memWrite = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      accum       <= `IOD_ACCUM_RST;
      memWrAddr   <= '0;
      memWrite    <= 1'b0;
      memWrData   <= 8'h00;
      statusWrite <= 1'b0;
      carryOut    <= 1'b0;
    end else begin
      accum       <= next_accum;
      memWrAddr   <= next_memWrAddr;
      memWrite    <= next_memWrite;
      memWrData   <= next_memWrData;
      statusWrite <= next_statusWrite;
      carryOut    <= next_carryOut;
    end
  end

endmodule : iod_core

`default_nettype wire

// [rtl/iod_defines.svh]
`ifndef IOD_DEFINES_SVH
`define IOD_DEFINES_SVH

// Register indices on the plain register port
`define IOD_REG_CTRL      4'h0
`define IOD_REG_FRAME     4'h1
`define IOD_REG_BANK      4'h2
`define IOD_REG_ACCUM     4'h3
`define IOD_REG_LASTADDR  4'h4

// Field positions
`define IOD_CTRL_EXT_BIT  0
`define IOD_ACCESS_BIT    8
`define IOD_DEST_BIT      9

// Reset values
`define IOD_CTRL_RST      1'b0
`define IOD_FRAME_RST     12'h000
`define IOD_BANK_RST      4'h0
`define IOD_ACCUM_RST     8'h00

// Highest argument that is taken as an offset
`define IOD_IDX_LIMIT     8'h5F

// Opcode patterns and the data value written by fill
`define IOD_ADD_OPC       6'h09
`define IOD_BITSET_OPC    4'h8
`define IOD_FILL_OPC      7'h34
`define IOD_FILL_VALUE    8'hFF

`endif

// [rtl/iod_pkg.sv]
`default_nettype none

package iod_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_BITSET,
    OP_FILL,
    OP_OTHER
  } iod_op_e;

  typedef struct packed {
    logic        valid;
    iod_op_e     op;
    logic [11:0] addr;
    logic        indexed;
    logic        destMem;
    logic [2:0]  bitSel;
  } iod_dec_s;

endpackage : iod_pkg

`default_nettype wire

// [test/iod_core_props.sv]
`timescale 1ns/10ps
`default_nettype none
module iod_core_props (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        instrValid,
  input wire logic [15:0] instrWord,
  input wire logic        fileOp,
  input wire logic [7:0]  memRdData,
  input wire logic [11:0] memAddr,
  input wire logic        memRead,
  input wire logic [11:0] memWrAddr,
  input wire logic        memWrite,
  input wire logic [7:0]  memWrData,
  input wire logic        statusWrite,
  input wire logic        extEnabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic tkn;
  logic isAdd;
  assign tkn = instrValid && fileOp;
  assign isAdd = tkn && instrWord[15:10] == 6'h09;
  a_bank_sel_addr: assert property (
    tkn && instrWord[8] |=> memRead && memAddr[7:0] == $past(instrWord[7:0]))
    else $error("bank address wrong");
  a_high_arg_lit: assert property (
    tkn && !instrWord[8] && instrWord[7:0] > 8'h5F
    |=> memAddr == {4'hF, $past(instrWord[7:0])})
    else $error("high argument not literal");
  a_ext_off_lit: assert property (
    tkn && !instrWord[8] && instrWord[7:0] <= 8'h5F && !extEnabled
    |=> memAddr == {4'h0, $past(instrWord[7:0])})
    else $error("access address wrong");
  a_fill_ones: assert property (
    tkn && instrWord[15:9] == 7'h34 |-> ##3 memWrite && memWrData == 8'hFF && !statusWrite)
    else $error("fill wrong");
  a_dest_acc: assert property (
    isAdd && !instrWord[9] |-> ##3 statusWrite && !memWrite)
    else $error("add to accumulator wrong");
  a_dest_mem: assert property (
    isAdd && instrWord[9] |-> ##3 memWrite && memWrAddr == $past(memAddr, 2))
    else $error("add to memory wrong");
  a_read_cause: assert property (
    memRead |-> $past(instrValid) && $past(fileOp))
    else $error("stray read");
  a_set_bit: assert property (
    tkn && instrWord[15:12] == 4'h8 |-> ##3 memWrite
    && memWrData == ($past(memRdData) | (8'h01 << $past(instrWord[11:9], 3))))
    else $error("bit set wrong");
endmodule : iod_core_props
bind iod_core iod_core_props u_props (.sys_clk(sys_clk), .nrst(nrst), .instrValid(instrValid),
  .instrWord(instrWord), .fileOp(fileOp), .memRdData(memRdData), .memAddr(memAddr),
  .memRead(memRead), .memWrAddr(memWrAddr), .memWrite(memWrite), .memWrData(memWrData),
  .statusWrite(statusWrite), .extEnabled(extEnabled));
`default_nettype wire

// [test/iod_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module iod_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] memAddr,
  input  wire logic        memRead,
  output logic      [7:0]  memRdData
);
  initial memRdData = 8'h00;
  // Data stands one cycle after a read, then toggles
  always @(posedge sys_clk) begin
    if (memRead) memRdData <= memAddr[7:0] + 8'h11;
    else memRdData <= ~memRdData;
  end
endmodule : iod_mem_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        instrValid = 1'b0, fileOp = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, instrWord = 16'h0000, regRdData;
  logic [7:0]  memRdData, memWrData;
  logic [11:0] memAddr, memWrAddr;
  logic        memRead, memWrite, statusWrite, carryOut, extEnabled;
  int          n_errors = 0, comparisons = 0;
  iod_core #(.ADDR_W(12)) dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .instrValid(instrValid), .instrWord(instrWord), .fileOp(fileOp), .memRdData(memRdData),
    .memAddr(memAddr), .memRead(memRead), .memWrAddr(memWrAddr), .memWrite(memWrite),
    .memWrData(memWrData), .statusWrite(statusWrite), .carryOut(carryOut),
    .extEnabled(extEnabled));
  iod_mem_model mem (.sys_clk(sys_clk), .memAddr(memAddr), .memRead(memRead),
    .memRdData(memRdData));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk("regRdData", {4'h0, exp}, {4'h0, regRdData});
  endtask : rd
  task automatic ins(input logic [15:0] w, input logic [11:0] ea, input logic we,
                     input logic [7:0] wd);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord <= w;
    fileOp <= 1'b1;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    fileOp <= 1'b0;
    #1 chk("memAddr", {8'h00, ea}, {8'h00, memAddr});
    repeat (2) @(posedge sys_clk);
    #1 chk("memWrite", {19'h0, we}, {19'h0, memWrite});
    if (we) chk("memWrAddr_Data", {ea, wd}, {memWrAddr, memWrData});
  endtask : ins
  task automatic t_reset;
    rd(4'h0, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(4'h7, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_literal;
    wr(4'h2, 16'h0005);
    wr(4'h1, 16'h0A00);
    ins(16'h242C, 12'h02C, 1'b0, 8'h00);
    rd(4'h3, 16'h003D);
    ins(16'h252C, 12'h52C, 1'b0, 8'h00);
    ins(16'h2660, 12'hF60, 1'b1, 8'hEB);
    $display("test literal done");
  endtask : t_literal
  task automatic t_indexed;
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    ins(16'h262C, 12'hA2C, 1'b1, 8'hB7);
    ins(16'h2660, 12'hF60, 1'b1, 8'hEB);
    ins(16'h272C, 12'h52C, 1'b1, 8'hB7);
    ins(16'h242C, 12'hA2C, 1'b0, 8'h00);
    rd(4'h3, 16'h00B7);
    $display("test indexed done");
  endtask : t_indexed
  task automatic t_ops;
    ins(16'h8E0A, 12'hA0A, 1'b1, 8'h9B);
    ins(16'h680A, 12'hA0A, 1'b1, 8'hFF);
    ins(16'h500A, 12'hA0A, 1'b0, 8'h00);
    $display("test ops done");
  endtask : t_ops
  task automatic t_wrap;
    wr(4'h1, 16'h0FF0);
    ins(16'h6820, 12'h010, 1'b1, 8'hFF);
    wr(4'h1, 16'h0000);
    ins(16'h682C, 12'h02C, 1'b1, 8'hFF);
    rd(4'h4, 16'h002C);
    ins(16'h267E, 12'hF7E, 1'b1, 8'h46);
    chk("carryOut", 20'h00001, {19'h0, carryOut});
    wr(4'h0, 16'h0000);
    #1 chk("extEnabled", 20'h00000, {19'h0, extEnabled});
    $display("test wrap done");
  endtask : t_wrap
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_literal();
    t_indexed();
    t_ops();
    t_wrap();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
